// ===== hdl/can_timing_pkg.sv
package can_timing_pkg;

  localparam int          BRP_W          = 11;
  localparam int          SEG_W          = 9;
  localparam int          NQ_W           = 10;
  localparam int          PROD_W         = 21;
  localparam int          ERR_W          = 9;
  localparam int          CLK_SEL_W      = 2;

  localparam logic [BRP_W-1:0] BRP_MIN   = 11'h001;
  localparam logic [BRP_W-1:0] BRP_MAX   = 11'h400;
  localparam logic [SEG_W-1:0] SEG_MIN   = 9'h001;
  localparam logic [SEG_W-1:0] NOM_SEG_MAX  = 9'h080;
  localparam logic [SEG_W-1:0] DATA_SEG_MAX = 9'h010;
  localparam logic [NQ_W-1:0]  SYNC_SEG_TQ  = 10'h001;

  localparam logic [ERR_W-1:0] WARN_LIMIT    = 9'h060;
  localparam logic [ERR_W-1:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [ERR_W-1:0] BUS_OFF_LIMIT = 9'h0FF;

  localparam logic [31:0] RATE_MIN_BPS      = 32'h0000_4E20;
  localparam logic [31:0] NOM_RATE_MAX_BPS  = 32'h000F_4240;
  localparam logic [31:0] DATA_RATE_MAX_BPS = 32'h0098_9680;

  localparam logic [31:0] CLK_HZ_SEL0 = 32'h04C4_B400;
  localparam logic [31:0] CLK_HZ_SEL1 = 32'h0393_8700;
  localparam logic [31:0] CLK_HZ_SEL2 = 32'h0262_5A00;
  localparam logic [31:0] CLK_HZ_SEL3 = 32'h0131_2D00;

  // Gray codes along active, warning, passive, bus-off
  typedef enum logic [2:0] {
    ST_ACTIVE   = 3'h0,
    ST_WARNING  = 3'h1,
    ST_PASSIVE  = 3'h3,
    ST_BUS_OFF  = 3'h2,
    ST_INACTIVE = 3'h6
  } fault_state_t;

  function automatic logic [31:0] core_clock_hz(input logic [CLK_SEL_W-1:0] sel);
    case (sel)
      2'h0:    core_clock_hz = CLK_HZ_SEL0;
      2'h1:    core_clock_hz = CLK_HZ_SEL1;
      2'h2:    core_clock_hz = CLK_HZ_SEL2;
      default: core_clock_hz = CLK_HZ_SEL3;
    endcase
  endfunction : core_clock_hz

  function automatic logic in_range(input logic [SEG_W-1:0] v,
                                    input logic [SEG_W-1:0] lo,
                                    input logic [SEG_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

endpackage : can_timing_pkg

// ===== hdl/bit_timing_check.sv
`timescale 1ns/100ps
`default_nettype none
module bit_timing_check
  import can_timing_pkg::*;
#(
  parameter logic [SEG_W-1:0] SEG_MAX  = NOM_SEG_MAX,
  parameter logic [31:0]      RATE_MAX = NOM_RATE_MAX_BPS
) (
  input  wire logic [BRP_W-1:0]  prescaler_in,
  input  wire logic [SEG_W-1:0]  prop_seg_in,
  input  wire logic [SEG_W-1:0]  phase_one_in,
  input  wire logic [SEG_W-1:0]  phase_two_in,
  input  wire logic [SEG_W-1:0]  jump_width_in,
  input  wire logic [SEG_W-1:0]  first_seg_in,
  input  wire logic [SEG_W-1:0]  second_seg_in,
  input  wire logic              compact_form_in,
  input  wire logic [31:0]       clock_hz_in,
  output logic      [SEG_W-1:0]  first_seg_out,
  output logic      [SEG_W-1:0]  second_seg_out,
  output logic      [PROD_W-1:0] divisor_out,
  output logic                   valid_out
);

  wire logic [NQ_W-1:0]  quanta;
  wire logic [63:0]      lower_bound;
  wire logic [63:0]      upper_bound;
  wire logic [63:0]      clock_ext;
  wire logic             brp_ok;
  wire logic             seg_ok;
  wire logic             sjw_ok;
  wire logic             rate_ok;
  wire logic [SEG_W-1:0] sum_seg;

  assign brp_ok = (prescaler_in >= BRP_MIN) && (prescaler_in <= BRP_MAX);

  assign sum_seg = SEG_W'(prop_seg_in + phase_one_in);
  assign first_seg_out = compact_form_in ? first_seg_in : sum_seg;
  assign second_seg_out = compact_form_in ? second_seg_in : phase_two_in;

  assign seg_ok = compact_form_in ?
    (in_range(first_seg_in, SEG_W'(SEG_MIN + SEG_MIN), SEG_W'(SEG_MAX + SEG_MAX)) &&
     in_range(second_seg_in, SEG_MIN, SEG_MAX)) :
    (in_range(prop_seg_in, SEG_MIN, SEG_MAX) && in_range(phase_one_in, SEG_MIN, SEG_MAX) &&
     in_range(phase_two_in, SEG_MIN, SEG_MAX));
  assign sjw_ok = in_range(jump_width_in, SEG_MIN, SEG_MAX);

  assign quanta = NQ_W'(SYNC_SEG_TQ + first_seg_out + second_seg_out);
  assign divisor_out = PROD_W'(prescaler_in * quanta);

  // Multiplying out avoids a divider in the check
  assign clock_ext   = 64'(clock_hz_in);
  assign lower_bound = 64'(RATE_MIN_BPS) * 64'(divisor_out);
  assign upper_bound = 64'(RATE_MAX) * 64'(divisor_out);
  assign rate_ok = (clock_ext >= lower_bound) && (clock_ext <= upper_bound);

  assign valid_out = brp_ok && seg_ok && sjw_ok && rate_ok;

endmodule : bit_timing_check
`default_nettype wire

// ===== hdl/fault_confinement.sv
`timescale 1ns/100ps
`default_nettype none
module fault_confinement
  import can_timing_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             ce_in,
  input  wire logic             chan_reset_in,
  input  wire logic             chan_active_in,
  input  wire logic [ERR_W-1:0] error_count_in,
  output fault_state_t          fault_state_out
);

  fault_state_t next_state;

  always_comb begin
    next_state = fault_state_out;
    case (fault_state_out)
      // Bus-off holds until a channel reset
      ST_BUS_OFF: next_state = ST_BUS_OFF;
      ST_ACTIVE, ST_WARNING, ST_PASSIVE, ST_INACTIVE: begin
        if (!chan_active_in) begin
          next_state = ST_INACTIVE;
        end else if (error_count_in > BUS_OFF_LIMIT) begin
          next_state = ST_BUS_OFF;
        end else if (error_count_in >= PASSIVE_LIMIT) begin
          next_state = ST_PASSIVE;
        end else if (error_count_in >= WARN_LIMIT) begin
          next_state = ST_WARNING;
        end else begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_INACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      fault_state_out <= ST_INACTIVE;
    end else if (ce_in) begin
      if (chan_reset_in) begin
        fault_state_out <= ST_INACTIVE;
      end else begin
        fault_state_out <= next_state;
      end
    end
  end

endmodule : fault_confinement
`default_nettype wire

// ===== hdl/can_bit_timing_and_status.sv
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_and_status
  import can_timing_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 ce_in,
  input  wire logic                 chan_active_in,
  input  wire logic                 listen_only_in,
  input  wire logic                 fd_enable_in,
  input  wire logic                 compact_form_in,
  input  wire logic [CLK_SEL_W-1:0] clock_sel_in,
  input  wire logic [BRP_W-1:0]     nom_prescaler_in,
  input  wire logic [SEG_W-1:0]     nom_prop_seg_in,
  input  wire logic [SEG_W-1:0]     nom_phase_one_in,
  input  wire logic [SEG_W-1:0]     nom_phase_two_in,
  input  wire logic [SEG_W-1:0]     nom_jump_width_in,
  input  wire logic [SEG_W-1:0]     nominal_first_segment_in,
  input  wire logic [SEG_W-1:0]     nominal_second_segment_in,
  input  wire logic [BRP_W-1:0]     fast_prescaler_in,
  input  wire logic [SEG_W-1:0]     fast_prop_seg_in,
  input  wire logic [SEG_W-1:0]     fast_phase_one_in,
  input  wire logic [SEG_W-1:0]     fast_phase_two_in,
  input  wire logic [SEG_W-1:0]     fast_jump_width_in,
  input  wire logic [SEG_W-1:0]     fast_phase_first_segment_in,
  input  wire logic [SEG_W-1:0]     fast_phase_second_segment_in,
  input  wire logic                 cfg_write_in,
  input  wire logic                 chan_reset_in,
  input  wire logic [ERR_W-1:0]     error_count_in,
  input  wire logic                 in_fast_phase_in,
  output logic                      cfg_accept_out,
  output logic                      cfg_reject_out,
  output logic                      listen_only_out,
  output logic                      fd_enable_out,
  output logic [CLK_SEL_W-1:0]      controller_core_clock_out,
  output logic [BRP_W-1:0]          nom_prescaler_out,
  output logic [SEG_W-1:0]          nominal_first_segment_out,
  output logic [SEG_W-1:0]          nominal_second_segment_out,
  output logic [SEG_W-1:0]          nom_jump_width_out,
  output logic [BRP_W-1:0]          fast_prescaler_out,
  output logic [SEG_W-1:0]          fast_phase_first_segment_out,
  output logic [SEG_W-1:0]          fast_phase_second_segment_out,
  output logic [SEG_W-1:0]          fast_jump_width_out,
  output fault_state_t              fault_state_out,
  output logic                      bus_off_out,
  output logic                      tx_enable_out,
  output logic                      ack_enable_out,
  output logic                      ctrl_reset_out,
  output logic                      bit_start_out,
  output logic                      sample_point_out
);

  // ****************************************
  // Candidate checks
  // ****************************************
  wire logic [31:0]       clock_hz;
  wire logic [SEG_W-1:0]  cand_nom_first;
  wire logic [SEG_W-1:0]  cand_nom_second;
  wire logic [SEG_W-1:0]  cand_fast_first;
  wire logic [SEG_W-1:0]  cand_fast_second;
  wire logic [PROD_W-1:0] nom_divisor;
  wire logic [PROD_W-1:0] fast_divisor;
  wire logic              nom_ok;
  wire logic              fast_ok;
  wire logic              order_ok;
  wire logic              cfg_ok;

  assign clock_hz = core_clock_hz(clock_sel_in);

  bit_timing_check #(
    .SEG_MAX  (NOM_SEG_MAX),
    .RATE_MAX (NOM_RATE_MAX_BPS)
  ) nom_check (
    .prescaler_in    (nom_prescaler_in),
    .prop_seg_in     (nom_prop_seg_in),
    .phase_one_in    (nom_phase_one_in),
    .phase_two_in    (nom_phase_two_in),
    .jump_width_in   (nom_jump_width_in),
    .first_seg_in    (nominal_first_segment_in),
    .second_seg_in   (nominal_second_segment_in),
    .compact_form_in (compact_form_in),
    .clock_hz_in     (clock_hz),
    .first_seg_out   (cand_nom_first),
    .second_seg_out  (cand_nom_second),
    .divisor_out     (nom_divisor),
    .valid_out       (nom_ok)
  );

  bit_timing_check #(
    .SEG_MAX  (DATA_SEG_MAX),
    .RATE_MAX (DATA_RATE_MAX_BPS)
  ) fast_check (
    .prescaler_in    (fast_prescaler_in),
    .prop_seg_in     (fast_prop_seg_in),
    .phase_one_in    (fast_phase_one_in),
    .phase_two_in    (fast_phase_two_in),
    .jump_width_in   (fast_jump_width_in),
    .first_seg_in    (fast_phase_first_segment_in),
    .second_seg_in   (fast_phase_second_segment_in),
    .compact_form_in (compact_form_in),
    .clock_hz_in     (clock_hz),
    .first_seg_out   (cand_fast_first),
    .second_seg_out  (cand_fast_second),
    .divisor_out     (fast_divisor),
    .valid_out       (fast_ok)
  );

  assign order_ok = fast_divisor <= nom_divisor;
  assign cfg_ok = nom_ok && (!fd_enable_in || (fast_ok && order_ok));

  // ****************************************
  // Committed settings
  // ****************************************
  wire logic commit;
  assign commit = ce_in && cfg_write_in && cfg_ok;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cfg_accept_out <= 1'b0;
      cfg_reject_out <= 1'b0;
    end else if (ce_in) begin
      cfg_accept_out <= cfg_write_in && cfg_ok;
      cfg_reject_out <= cfg_write_in && !cfg_ok;
    end
  end

  // Reset values equal candidate minimums; software commits before use
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      listen_only_out               <= 1'b0;
      fd_enable_out                 <= 1'b0;
      controller_core_clock_out     <= '0;
      nom_prescaler_out             <= BRP_MIN;
      nominal_first_segment_out     <= SEG_W'(SEG_MIN + SEG_MIN);
      nominal_second_segment_out    <= SEG_MIN;
      nom_jump_width_out            <= SEG_MIN;
      fast_prescaler_out            <= BRP_MIN;
      fast_phase_first_segment_out  <= SEG_W'(SEG_MIN + SEG_MIN);
      fast_phase_second_segment_out <= SEG_MIN;
      fast_jump_width_out           <= SEG_MIN;
    end else if (commit) begin
      listen_only_out               <= listen_only_in;
      fd_enable_out                 <= fd_enable_in;
      controller_core_clock_out     <= clock_sel_in;
      nom_prescaler_out             <= nom_prescaler_in;
      nominal_first_segment_out     <= cand_nom_first;
      nominal_second_segment_out    <= cand_nom_second;
      nom_jump_width_out            <= nom_jump_width_in;
      fast_prescaler_out            <= fast_prescaler_in;
      fast_phase_first_segment_out  <= cand_fast_first;
      fast_phase_second_segment_out <= cand_fast_second;
      fast_jump_width_out           <= fast_jump_width_in;
    end
  end

  // ****************************************
  // Fault confinement and bus access
  // ****************************************
  fault_confinement fault_fsm (
    .sys_clk_in      (sys_clk_in),
    .reset_n_in      (reset_n_in),
    .ce_in           (ce_in),
    .chan_reset_in   (chan_reset_in),
    .chan_active_in  (chan_active_in),
    .error_count_in  (error_count_in),
    .fault_state_out (fault_state_out)
  );

  wire logic on_bus;
  assign on_bus = chan_active_in && !listen_only_out && !chan_reset_in &&
                  (error_count_in <= BUS_OFF_LIMIT) && (fault_state_out != ST_BUS_OFF);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      bus_off_out    <= 1'b0;
      tx_enable_out  <= 1'b0;
      ack_enable_out <= 1'b0;
      ctrl_reset_out <= 1'b0;
    end else if (ce_in) begin
      bus_off_out    <= !chan_reset_in && chan_active_in &&
                        ((fault_state_out == ST_BUS_OFF) || (error_count_in > BUS_OFF_LIMIT));
      tx_enable_out  <= on_bus;
      ack_enable_out <= on_bus;
      ctrl_reset_out <= chan_reset_in;
    end
  end

  // ****************************************
  // Quantum and bit segment counters
  // ****************************************
  wire logic              use_fast;
  wire logic [BRP_W-1:0]  cur_brp;
  wire logic [SEG_W-1:0]  cur_first;
  wire logic [NQ_W-1:0]   cur_last_q;
  wire logic              tq_tick;
  logic      [BRP_W-1:0]  tq_count;
  logic      [NQ_W-1:0]   quantum;

  assign use_fast   = fd_enable_out && in_fast_phase_in;
  assign cur_brp    = use_fast ? fast_prescaler_out : nom_prescaler_out;
  assign cur_first  = use_fast ? fast_phase_first_segment_out : nominal_first_segment_out;
  assign cur_last_q = NQ_W'(cur_first + (use_fast ? fast_phase_second_segment_out :
                                         nominal_second_segment_out));
  assign tq_tick    = tq_count >= BRP_W'(cur_brp - BRP_MIN);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || chan_reset_in) begin
      tq_count <= '0;
      quantum  <= '0;
    end else if (ce_in) begin
      tq_count <= tq_tick ? '0 : BRP_W'(tq_count + BRP_MIN);
      if (tq_tick) begin
        quantum <= (quantum >= cur_last_q) ? '0 : NQ_W'(quantum + SYNC_SEG_TQ);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || chan_reset_in) begin
      bit_start_out    <= 1'b0;
      sample_point_out <= 1'b0;
    end else if (ce_in) begin
      bit_start_out    <= tq_tick && (quantum == '0);
      sample_point_out <= tq_tick && (quantum == NQ_W'(cur_first));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking main_cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  err_active_state_a: assert property (
    (ce_in && !chan_reset_in && chan_active_in && error_count_in < WARN_LIMIT &&
     fault_state_out != ST_BUS_OFF) |=> fault_state_out == ST_ACTIVE)
    else $error("active state not reported below warning level");

  err_warning_state_a: assert property (
    (ce_in && !chan_reset_in && chan_active_in && error_count_in == WARN_LIMIT &&
     fault_state_out != ST_BUS_OFF) |=> fault_state_out == ST_WARNING)
    else $error("warning state not reported at warning level");

  err_passive_state_a: assert property (
    (ce_in && !chan_reset_in && chan_active_in && error_count_in == PASSIVE_LIMIT &&
     fault_state_out != ST_BUS_OFF) |=> fault_state_out == ST_PASSIVE)
    else $error("passive state not reported at passive level");

  bus_off_entry_a: assert property (
    (ce_in && !chan_reset_in && chan_active_in && error_count_in > BUS_OFF_LIMIT)
    |=> (fault_state_out == ST_BUS_OFF) && bus_off_out && !tx_enable_out)
    else $error("bus-off not entered above limit");

  listen_silent_a: assert property (
    listen_only_out && $past(listen_only_out) |-> !tx_enable_out && !ack_enable_out)
    else $error("listen-only channel drives the bus");

  prescaler_zero_a: assert property (
    (ce_in && cfg_write_in && nom_prescaler_in == '0) |=> cfg_reject_out)
    else $error("zero prescaler accepted");

  rate_order_a: assert property (
    (ce_in && cfg_write_in && fd_enable_in && fast_divisor > nom_divisor)
    |=> cfg_reject_out && !cfg_accept_out)
    else $error("data rate below nominal accepted");

  keep_previous_a: assert property (
    (cfg_write_in && !cfg_ok)
    |=> $stable(nom_prescaler_out) && $stable(nominal_first_segment_out) &&
        $stable(fd_enable_out))
    else $error("rejected settings changed committed timing");

  chan_reset_a: assert property (
    (ce_in && chan_reset_in) |=> ctrl_reset_out && fault_state_out == ST_INACTIVE
    ##1 !ctrl_reset_out || $past(chan_reset_in))
    else $error("channel reset did not reinitialize state");

  jump_width_a: assert property (
    (ce_in && cfg_write_in &&
     (nom_jump_width_in < SEG_MIN || nom_jump_width_in > NOM_SEG_MAX)) |=> cfg_reject_out)
    else $error("out-of-range jump width accepted");

  data_seg_range_a: assert property (
    (ce_in && cfg_write_in && fd_enable_in && !compact_form_in &&
     fast_prop_seg_in > DATA_SEG_MAX) |=> cfg_reject_out)
    else $error("out-of-range data propagation segment accepted");

  nominal_only_a: assert property (
    (ce_in && cfg_write_in && !fd_enable_in && nom_ok) |=> cfg_accept_out)
    else $error("data timing blocked a nominal-only commit");

  first_seg_sum_a: assert property (
    (cfg_accept_out && $past(ce_in) && !$past(compact_form_in)) |->
      nominal_first_segment_out == SEG_W'($past(nom_prop_seg_in) + $past(nom_phase_one_in)))
    else $error("first segment is not propagation plus phase one");

  cover_commit_c:  cover property (cfg_accept_out ##[1:1000] bit_start_out);
  cover_reject_c:  cover property (cfg_reject_out);
  cover_passive_c: cover property (fault_state_out == ST_WARNING ##[1:20]
                                   fault_state_out == ST_PASSIVE);
  cover_bus_off_c: cover property (bus_off_out ##[1:20] ctrl_reset_out);

endmodule : can_bit_timing_and_status
`default_nettype wire

// ===== testbench/can_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module can_peer_model
  import can_timing_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [ERR_W-1:0] target_count_in,
  output logic      [ERR_W-1:0] error_count_out,
  output logic                  fast_phase_out
);
  logic [5:0] phase_cnt;
  // ************************************************
  // Error count seen from bus traffic
  // ************************************************
  // One step a cycle, so every state on the way is passed through
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      error_count_out <= 9'h000;
      phase_cnt       <= 6'h00;
    end else begin
      phase_cnt <= phase_cnt + 6'h01;
      if (error_count_out < target_count_in) begin
        error_count_out <= error_count_out + 9'h001;
      end else if (error_count_out > target_count_in) begin
        error_count_out <= error_count_out - 9'h001;
      end
    end
  end
  // Peers run a data phase every other 32 cycles
  assign fast_phase_out = phase_cnt[5];
endmodule : can_peer_model
`default_nettype wire

// ===== testbench/can_bit_timing_and_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_and_status_tb_top
  import can_timing_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, act = 1'b0, lo = 1'b0, fd = 1'b0, cm = 1'b0, wr = 1'b0;
  logic crst = 1'b0, fph;
  logic [1:0] sel = 2'h0;
  logic [10:0] nb = 11'h001, fb = 11'h001;
  logic [8:0] na = 9'h001, nbb = 9'h001, nc = 9'h001, fa = 9'h001, fbb = 9'h001, fc = 9'h001;
  logic [8:0] tgt = 9'h000, cnt;
  logic [8:0] nj = 9'h001, fj = 9'h001, nj_o, fj_o;
  logic bst, spt;
  logic acc, rej, lo_o, fd_o, txe, acke, boff, crst_o;
  logic [1:0] sel_o;
  logic [10:0] nb_o, fb_o;
  logic [8:0] n1_o, n2_o, f1_o, f2_o;
  fault_state_t st;
  int miscompares = 0, comparisons = 0;
  always #25 clk = ~clk;
  can_peer_model peer (.sys_clk_in(clk), .reset_n_in(rst_n), .target_count_in(tgt),
    .error_count_out(cnt), .fast_phase_out(fph));
  can_bit_timing_and_status dut (.sys_clk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1),
    .chan_active_in(act), .listen_only_in(lo), .fd_enable_in(fd), .compact_form_in(cm),
    .clock_sel_in(sel), .nom_prescaler_in(nb), .nom_prop_seg_in(na), .nom_phase_one_in(nbb),
    .nom_phase_two_in(nc), .nom_jump_width_in(nj), .nominal_first_segment_in(na),
    .nominal_second_segment_in(nbb), .fast_prescaler_in(fb), .fast_prop_seg_in(fa),
    .fast_phase_one_in(fbb), .fast_phase_two_in(fc), .fast_jump_width_in(fj),
    .fast_phase_first_segment_in(fa), .fast_phase_second_segment_in(fbb), .cfg_write_in(wr),
    .chan_reset_in(crst), .error_count_in(cnt), .in_fast_phase_in(fph), .cfg_accept_out(acc),
    .cfg_reject_out(rej), .listen_only_out(lo_o), .fd_enable_out(fd_o),
    .controller_core_clock_out(sel_o), .nom_prescaler_out(nb_o), .nominal_first_segment_out(n1_o),
    .nominal_second_segment_out(n2_o), .nom_jump_width_out(nj_o), .fast_prescaler_out(fb_o),
    .fast_phase_first_segment_out(f1_o), .fast_phase_second_segment_out(f2_o),
    .fast_jump_width_out(fj_o), .fault_state_out(st), .bus_off_out(boff), .tx_enable_out(txe),
    .ack_enable_out(acke), .ctrl_reset_out(crst_o), .bit_start_out(bst), .sample_point_out(spt));
  // ************************************************
  // Compare and report
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ************************************************
  // Scenario tasks
  // ************************************************
  // Commit attempt; a refused one must leave old settings in place
  task automatic cfg(input logic c, f, l, input logic [1:0] s, input logic [10:0] b,
                     input logic [8:0] x, y, z, input logic [10:0] q,
                     input logic [8:0] u, v, w, input logic ok);
    logic [31:0] p1, pb;
    p1 = n1_o;
    pb = nb_o;
    @(posedge clk);
    cm <= c; fd <= f; lo <= l; sel <= s; nb <= b; na <= x; nbb <= y; nc <= z;
    fb <= q; fa <= u; fbb <= v; fc <= w; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk(acc, ok);
    chk(rej, !ok);
    if (ok) begin
      chk(n1_o, c ? x : x + y);
      chk(n2_o, c ? y : z);
      chk(nb_o, b);
      chk(sel_o, s);
      chk(fd_o, f);
      chk(lo_o, l);
      chk(nj_o, nj);
      if (f) chk(fj_o, fj);
      if (f) chk(fb_o, q);
      if (f) chk(f1_o, c ? u : u + v);
      if (f) chk(f2_o, c ? v : w);
    end else begin
      chk(n1_o, p1);
      chk(nb_o, pb);
    end
    @(posedge clk);
    #1 chk(acc | rej, 1'b0);
  endtask : cfg
  task automatic fault_at(input logic [8:0] n, input fault_state_t e);
    int i;
    tgt <= n;
    for (i = 0; i < 600 && cnt !== n; i++) @(posedge clk);
    if (i == 600) begin
      chk(cnt, n);
      results();
    end
    repeat (3) @(posedge clk);
    #1 chk(st, e);
    chk(boff, e == ST_BUS_OFF);
  endtask : fault_at
  task automatic bit_timing(input int first, input int second, input int brp);
    int i, s, p;
    s = -1;
    for (i = 0; i < 4000 && bst !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    for (p = 1; p < 4000; p++) begin
      @(posedge clk);
      #1;
      if (spt === 1'b1) s = p;
      if (bst === 1'b1) break;
    end
    chk(s, brp * first);
    chk(p, brp * (1 + first + second));
    if (p == 4000) results();
  endtask : bit_timing
  // jump width bounds in both phases
  task automatic jump_width();
    @(posedge clk);
    nj <= 9'h081;
    cfg(0, 0, 0, 2'h0, 11'h001, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 0);
    @(posedge clk);
    nj <= 9'h080;
    cfg(0, 0, 0, 2'h0, 11'h001, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 1);
    @(posedge clk);
    fj <= 9'h011;
    cfg(0, 1, 0, 2'h0, 11'h005, 9'h00F, 9'h008, 9'h008, 11'h005, 1, 1, 1, 0);
    @(posedge clk);
    fj <= 9'h010;
    cfg(0, 1, 0, 2'h0, 11'h005, 9'h00F, 9'h008, 9'h008, 11'h005, 1, 1, 1, 1);
  endtask : jump_width
  // channel reset leaves bus-off, keeps timing
  task automatic chan_reset();
    @(posedge clk);
    crst <= 1'b1;
    @(posedge clk);
    crst <= 1'b0;
    #1 chk(crst_o, 1'b1);
    chk(st, ST_INACTIVE);
    repeat (3) @(posedge clk);
    #1 chk(st, ST_ACTIVE);
    chk(crst_o | boff, 1'b0);
    chk(nb_o, 11'h001);
  endtask : chan_reset
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    act   <= 1'b1;
    #1 chk(st, ST_INACTIVE);
    chk(nb_o, 11'h001);
    chk(n1_o, 9'h002);
    cfg(0, 0, 0, 2'h0, 11'h001, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 1);
    cfg(0, 0, 0, 2'h0, 11'h001, 9'h001, 9'h001, 9'h001, 11'h001, 1, 1, 1, 0);
    cfg(0, 0, 0, 2'h0, 11'h401, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 0);
    cfg(0, 0, 0, 2'h0, 11'h000, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 0);
    cfg(0, 0, 0, 2'h3, 11'h001, 9'h009, 9'h005, 9'h005, 11'h001, 1, 1, 1, 1);
    bit_timing(14, 5, 1);
    cfg(0, 0, 0, 2'h3, 11'h002, 9'h009, 9'h005, 9'h005, 11'h001, 1, 1, 1, 1);
    bit_timing(14, 5, 2);
    cfg(1, 1, 0, 2'h0, 11'h005, 9'h017, 9'h008, 0, 11'h005, 9'h002, 9'h001, 0, 1);
    cfg(1, 1, 0, 2'h0, 11'h005, 9'h017, 9'h008, 0, 11'h001, 9'h002, 9'h001, 0, 0);
    cfg(1, 1, 0, 2'h0, 11'h005, 9'h017, 9'h008, 0, 11'h00A, 9'h00F, 9'h004, 0, 0);
    cfg(0, 1, 0, 2'h0, 11'h005, 9'h00F, 9'h008, 9'h008, 11'h001, 9'h011, 1, 1, 0);
    cfg(0, 1, 0, 2'h0, 11'h005, 9'h00F, 9'h008, 9'h008, 11'h001, 1, 9'h011, 1, 0);
    jump_width();
    cfg(0, 0, 1, 2'h0, 11'h001, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 1);
    fault_at(9'h000, ST_ACTIVE);
    chk(txe | acke, 1'b0);
    cfg(0, 0, 0, 2'h0, 11'h001, 9'h02F, 9'h010, 9'h010, 11'h001, 1, 1, 1, 1);
    fault_at(9'h05F, ST_ACTIVE);
    chk(txe & acke, 1'b1);
    fault_at(9'h060, ST_WARNING);
    fault_at(9'h07F, ST_WARNING);
    fault_at(9'h080, ST_PASSIVE);
    fault_at(9'h0FF, ST_PASSIVE);
    fault_at(9'h100, ST_BUS_OFF);
    chk(txe | acke, 1'b0);
    fault_at(9'h000, ST_BUS_OFF);
    chan_reset();
    results();
  end
endmodule : can_bit_timing_and_status_tb_top
`default_nettype wire
